/* File: dmlp_map.svh */
`ifndef DMLP_MAP_SVH
`define DMLP_MAP_SVH
// timebase
`define DMLP_CLK_MHZ 50
// dot timing, in microseconds
`define DMLP_PULSE_US 400
`define DMLP_GAP_US 900
`define DMLP_MIN_PERIOD_US 1300
`define DMLP_CHGAP_US 900
// print area, in milliseconds
`define DMLP_AREA_MS 310
// ring buffer layout
`define DMLP_POSITIONS 40
`define DMLP_FIRST_POS 6'h00
`define DMLP_LAST_POS 6'h27
`define DMLP_PHANTOM_POS 6'h28
// character shape
`define DMLP_ROWS 7
`define DMLP_LAST_COL 3'h4
// handoff register marker for "vacant"
`define DMLP_VACANT 8'h00
`endif

/* File: dmlp_pkg.sv */
`default_nettype none
`include "dmlp_map.svh"
package dmlp_pkg;
    typedef enum logic [2:0] {
        DMLP_ARMED = 3'b000,
        DMLP_LOAD = 3'b001,
        DMLP_PULSE = 3'b010,
        DMLP_GAP = 3'b011,
        DMLP_CHGAP = 3'b100,
        DMLP_FEED_ON = 3'b101,
        DMLP_FEED_OFF = 3'b110,
        DMLP_IDLE = 3'b111
    } dmlp_state_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } dmlp_host_t;

    typedef struct packed {
        logic carriage_ready;
        logic feed_sw;
    } dmlp_mech_in_t;

    typedef struct packed {
        logic [`DMLP_ROWS-1:0] hammer;
        logic feed_motor;
        logic main_motor;
    } dmlp_mech_out_t;

    typedef struct packed {
        logic [`DMLP_POSITIONS-1:0][7:0] mem;
        logic [5:0] fill_index;
        logic [5:0] drain_index;
        logic [7:0] handoff;
        logic [7:0] cur_char;
        logic [2:0] column_index;
        logic [`DMLP_ROWS-1:0] pattern;
        logic [`DMLP_ROWS-1:0] hammer;
        dmlp_state_t fsm;
        logic [23:0] tmr;
        logic [23:0] area;
        logic feed_motor;
        logic main_motor;
        logic room;
    } dmlp_st_t;
endpackage
`default_nettype wire

/* File: dmlp_ctrl.sv */
// Operation
// - print-ready edge starts dot pulses
// - each dot pulse lasts 400 us
// - hammers idle 900 us between dots
// - no hammer fires faster than 1.3 ms
// - columns timed over 310 ms print area
// - feed motor on until switch off-on-off
// - after feed, wait carriage inactive, rearm
// - buffer holds 40 host characters
// - extra phantom slot halts handoff
// - fill is last stored, drain is next
// - init: fill last, drain phantom
// - store at next fill unless equals drain
// - drain moves to first when line full
// - print starts only with complete line
// - handoff loads when vacant, drain real
// - sequencer takes char, marks handoff vacant
// - glyph column held then driven out
// - after printing drain is phantom again, as at init
// - five columns of seven row dots
`default_nettype none
`include "dmlp_map.svh"
module dmlp_ctrl #(
    parameter int unsigned PULSE_CYC = `DMLP_PULSE_US * `DMLP_CLK_MHZ,
    parameter int unsigned GAP_CYC = `DMLP_GAP_US * `DMLP_CLK_MHZ,
    parameter int unsigned CHGAP_CYC = `DMLP_CHGAP_US * `DMLP_CLK_MHZ,
    parameter int unsigned AREA_CYC = `DMLP_AREA_MS * 1000 * `DMLP_CLK_MHZ
) (
    input wire logic clk,
    input wire logic rst,
    input wire dmlp_pkg::dmlp_host_t host,
    output logic host_ready,
    input wire dmlp_pkg::dmlp_mech_in_t mech_in,
    output dmlp_pkg::dmlp_mech_out_t mech_out
);
    // follows the scaled pulse and gap so small test timings keep the rate check honest
    localparam int unsigned MIN_PERIOD_CYC = PULSE_CYC + GAP_CYC;

    dmlp_pkg::dmlp_st_t q;
    dmlp_pkg::dmlp_st_t d;
    logic take;
    logic [5:0] nxt;

    // column c of a glyph, row 1 in bit 0; col 0 sits in the top bits
    function automatic logic [`DMLP_ROWS-1:0] dmlp_glyph(input logic [7:0] ch,
                                                         input logic [2:0] col);
        logic [34:0] g;
        begin
            unique case (ch)
                8'h20: g = '0;
                8'h30: g = {7'h3e, 7'h51, 7'h49, 7'h45, 7'h3e};
                8'h31: g = {7'h00, 7'h42, 7'h7f, 7'h40, 7'h00};
                8'h32: g = {7'h42, 7'h61, 7'h51, 7'h49, 7'h46};
                8'h33: g = {7'h21, 7'h41, 7'h45, 7'h4b, 7'h31};
                8'h34: g = {7'h18, 7'h14, 7'h12, 7'h7f, 7'h10};
                8'h35: g = {7'h27, 7'h45, 7'h45, 7'h45, 7'h39};
                8'h36: g = {7'h3c, 7'h4a, 7'h49, 7'h49, 7'h30};
                8'h37: g = {7'h01, 7'h71, 7'h09, 7'h05, 7'h03};
                8'h38: g = {7'h36, 7'h49, 7'h49, 7'h49, 7'h36};
                8'h39: g = {7'h06, 7'h49, 7'h49, 7'h29, 7'h1e};
                // unknown codes print a hollow box so they stay visible
                default: g = {7'h7f, 7'h41, 7'h41, 7'h41, 7'h7f};
            endcase
            return 7'(g >> (7 * (4 - int'(col))));
        end
    endfunction

    always_comb begin
        d = q;
        nxt = (q.fill_index == `DMLP_LAST_POS) ? `DMLP_FIRST_POS : q.fill_index + 6'h01;
        take = host.valid && q.room;
        if (q.tmr != '0) begin
            d.tmr = q.tmr - 24'h000001;
        end
        if (q.area != '0) begin
            d.area = q.area - 24'h000001;
        end
        // print timing sequencer runs first so a freed handoff refills at once
        unique case (q.fsm)
            dmlp_pkg::DMLP_ARMED: begin
                d.hammer = '0;
                if (mech_in.carriage_ready) begin
                    if (q.handoff != `DMLP_VACANT) begin
                        d.area = 24'(AREA_CYC - 1);
                        d.fsm = dmlp_pkg::DMLP_LOAD;
                    end else begin
                        d.main_motor = 1'b0;
                    end
                end
            end
            dmlp_pkg::DMLP_LOAD: begin
                if (q.area == '0 || q.handoff == `DMLP_VACANT) begin
                    d.feed_motor = 1'b1;
                    d.fsm = dmlp_pkg::DMLP_FEED_ON;
                end else begin
                    d.cur_char = q.handoff;
                    d.handoff = `DMLP_VACANT;
                    d.column_index = 3'h0;
                    d.pattern = dmlp_glyph(q.handoff, 3'h0);
                    d.tmr = '0;
                    d.fsm = dmlp_pkg::DMLP_GAP;
                end
            end
            dmlp_pkg::DMLP_GAP: begin
                if (q.tmr == '0) begin
                    if (q.area == '0) begin
                        d.feed_motor = 1'b1;
                        d.fsm = dmlp_pkg::DMLP_FEED_ON;
                    end else begin
                        d.hammer = q.pattern;
                        d.tmr = 24'(PULSE_CYC - 1);
                        d.fsm = dmlp_pkg::DMLP_PULSE;
                    end
                end
            end
            dmlp_pkg::DMLP_PULSE: begin
                if (q.tmr == '0) begin
                    d.hammer = '0;
                    if (q.column_index == `DMLP_LAST_COL) begin
                        d.tmr = 24'(GAP_CYC + CHGAP_CYC - 1);
                        d.fsm = dmlp_pkg::DMLP_CHGAP;
                    end else begin
                        d.column_index = q.column_index + 3'h1;
                        d.pattern = dmlp_glyph(q.cur_char, q.column_index + 3'h1);
                        d.tmr = 24'(GAP_CYC - 1);
                        d.fsm = dmlp_pkg::DMLP_GAP;
                    end
                end
            end
            dmlp_pkg::DMLP_CHGAP: begin
                if (q.tmr == '0) begin
                    d.fsm = dmlp_pkg::DMLP_LOAD;
                end
            end
            dmlp_pkg::DMLP_FEED_ON: begin
                if (mech_in.feed_sw) begin
                    d.fsm = dmlp_pkg::DMLP_FEED_OFF;
                end
            end
            dmlp_pkg::DMLP_FEED_OFF: begin
                if (!mech_in.feed_sw) begin
                    d.feed_motor = 1'b0;
                    d.fsm = dmlp_pkg::DMLP_IDLE;
                end
            end
            dmlp_pkg::DMLP_IDLE: begin
                // a stuck-active carriage switch never starts a second line
                if (!mech_in.carriage_ready) begin
                    d.fsm = dmlp_pkg::DMLP_ARMED;
                end
            end
        endcase
        // line buffer manager
        if (take) begin
            d.fill_index = nxt;
            d.mem[nxt] = host.data;
            d.main_motor = 1'b1;
            if (nxt == `DMLP_LAST_POS) begin
                d.drain_index = `DMLP_FIRST_POS;
            end
        end
        if (d.handoff == `DMLP_VACANT && d.drain_index <= `DMLP_LAST_POS) begin
            d.handoff = d.mem[d.drain_index];
            d.drain_index = d.drain_index + 6'h01;
        end
        d.room = (d.fill_index == `DMLP_LAST_POS ? `DMLP_FIRST_POS
                  : d.fill_index + 6'h01) != d.drain_index;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
            q.fill_index <= `DMLP_LAST_POS;
            q.drain_index <= `DMLP_PHANTOM_POS;
            q.handoff <= `DMLP_VACANT;
            q.fsm <= dmlp_pkg::DMLP_IDLE;
            q.room <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign host_ready = q.room;
    assign mech_out.hammer = q.hammer;
    assign mech_out.feed_motor = q.feed_motor;
    assign mech_out.main_motor = q.main_motor;

    // helper counters watched by the checks below
    logic [23:0] on_len;
    logic [23:0] off_len;
    logic [23:0] since_fire;
    always_ff @(posedge clk) begin
        if (rst) begin
            on_len <= '0;
            off_len <= '1;
            since_fire <= '1;
        end else begin
            on_len <= (|q.hammer) ? on_len + 24'h000001 : '0;
            if (|q.hammer) begin
                off_len <= '0;
            end else if (off_len != '1) begin
                off_len <= off_len + 24'h000001;
            end
            // restart on the first cycle a dot is out, so a rise sees the full period
            if ((|q.hammer) && on_len == '0) begin
                since_fire <= 24'h000001;
            end else if (since_fire != '1) begin
                since_fire <= since_fire + 24'h000001;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_edge_seen;
        q.fsm == dmlp_pkg::DMLP_ARMED && mech_in.carriage_ready
            && q.handoff != `DMLP_VACANT;
    endsequence
    sequence s_first_column;
        q.fsm == dmlp_pkg::DMLP_LOAD ##1 q.fsm == dmlp_pkg::DMLP_GAP
            ##1 q.fsm == dmlp_pkg::DMLP_PULSE;
    endsequence
    sequence s_feed_done;
        q.fsm == dmlp_pkg::DMLP_FEED_OFF && !mech_in.feed_sw;
    endsequence

    chk_line_start: assert property (s_edge_seen |=> s_first_column)
        else $error("line did not start on print-ready edge");
    chk_pulse_len: assert property ($fell(|q.hammer) |-> on_len == 24'(PULSE_CYC))
        else $error("dot pulse length wrong");
    chk_dot_gap: assert property ($rose(|q.hammer) |-> off_len >= 24'(GAP_CYC))
        else $error("gap between dots too short");
    chk_fire_rate: assert property ($rose(|q.hammer) |-> since_fire >= 24'(MIN_PERIOD_CYC))
        else $error("hammer fired too often");
    chk_area_dot: assert property ($rose(|q.hammer) |-> $past(q.area) != '0)
        else $error("dot fired outside print area");
    chk_feed_hold: assert property (
        q.fsm inside {dmlp_pkg::DMLP_FEED_ON, dmlp_pkg::DMLP_FEED_OFF} |-> q.feed_motor)
        else $error("feed motor dropped early");
    chk_feed_stop: assert property (s_feed_done |=> !q.feed_motor
        && q.fsm == dmlp_pkg::DMLP_IDLE)
        else $error("feed motor not stopped");
    chk_rearm_wait: assert property (
        q.fsm == dmlp_pkg::DMLP_IDLE && mech_in.carriage_ready |=> q.fsm == dmlp_pkg::DMLP_IDLE)
        else $error("rearmed while carriage active");
    chk_fill_hold: assert property (host.valid && !q.room |=> $stable(q.fill_index))
        else $error("fill index moved onto drain");
    chk_fill_step: assert property (host.valid && q.room |=> q.fill_index != $past(q.fill_index))
        else $error("character not stored");
    chk_drain_step: assert property ($changed(q.drain_index) |->
        q.drain_index == `DMLP_FIRST_POS || q.drain_index == $past(q.drain_index) + 6'h01
        || ($past(q.drain_index) == `DMLP_PHANTOM_POS && q.drain_index == 6'h01))
        else $error("drain index jumped");
    chk_handoff_load: assert property (q.handoff == `DMLP_VACANT
        |-> q.drain_index == `DMLP_PHANTOM_POS)
        else $error("handoff not refilled");
    chk_phantom_idle: assert property (q.drain_index == `DMLP_PHANTOM_POS
        && q.handoff == `DMLP_VACANT && !take |=> q.handoff == `DMLP_VACANT)
        else $error("handoff loaded from phantom slot");
    chk_accept_char: assert property (q.fsm == dmlp_pkg::DMLP_LOAD && q.area != '0
        && q.handoff != `DMLP_VACANT |=> q.cur_char == $past(q.handoff))
        else $error("current character not taken");
endmodule
`default_nettype wire

/* File: dmlp_mech_sim.sv */
`default_nettype none
// printer mechanism: carriage switch follows scan, feed switch follows the motor
module dmlp_mech_sim #(
    parameter int FEED_DLY = 30,
    parameter int FEED_LEN = 40
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic scan,
    input wire logic feed_motor,
    output var dmlp_pkg::dmlp_mech_in_t mech_in
);
    timeunit 1ns;
    timeprecision 1ns;
    int feed_cnt = 0;
    int off_cnt = 0;
    always @(posedge clk) begin
        if (rst) begin
            mech_in <= '0;
            feed_cnt <= 0;
            off_cnt <= 0;
        end else begin
            if (feed_motor) begin
                feed_cnt <= feed_cnt + 1;
                // switch closes late and opens early: motor must wait it out
                mech_in.feed_sw <= feed_cnt >= FEED_DLY && feed_cnt < FEED_DLY + FEED_LEN;
                off_cnt <= 1;
            end else begin
                feed_cnt <= 0;
                mech_in.feed_sw <= 1'b0;
                if (off_cnt > 0) off_cnt <= off_cnt + 1;
            end
            if (!scan) begin
                mech_in.carriage_ready <= 1'b0;
                off_cnt <= 0;
            end else if (off_cnt == 0) begin
                mech_in.carriage_ready <= 1'b1;
            end else if (off_cnt == 5) begin
                // head leaves print area some time after the feed
                mech_in.carriage_ready <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb.sv */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PULSE = 8;
    localparam int GAP = 12;
    localparam int FEED = 70;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic scan = 1'b0;
    dmlp_pkg::dmlp_host_t host = '0;
    logic host_ready;
    dmlp_pkg::dmlp_mech_in_t mech_in;
    dmlp_pkg::dmlp_mech_out_t mech_out;
    int fails = 0;
    int n_checks = 0;
    int n_pulses = 0;
    int hi_run = 0;
    int lo_run = 1000;
    int period = 1000;
    int feed_on = 0;

    always #10 clk = ~clk;

    dmlp_ctrl #(.PULSE_CYC(PULSE), .GAP_CYC(GAP), .CHGAP_CYC(12), .AREA_CYC(6000)) i_dmlp_ctrl (
        .clk(clk), .rst(rst), .host(host), .host_ready(host_ready),
        .mech_in(mech_in), .mech_out(mech_out));
    dmlp_mech_sim #(.FEED_DLY(30), .FEED_LEN(40)) i_dmlp_mech_sim (
        .clk(clk), .rst(rst), .scan(scan), .feed_motor(mech_out.feed_motor),
        .mech_in(mech_in));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (fails == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // dot monitor: width, gap and rate of every hammer pulse
    always @(posedge clk) begin
        period++;
        if (mech_out.feed_motor === 1'b1) feed_on++;
        if (rst) begin
            hi_run = 0;
        end else if (mech_out.hammer !== 7'h00) begin
            if (hi_run == 0) begin
                n_pulses++;
                check(lo_run >= GAP, 1'b1, "dot gap");
                check(period >= PULSE + GAP, 1'b1, "dot rate");
                period = 0;
            end
            hi_run++;
            check(mech_out.feed_motor, 1'b0, "hammer during feed");
        end else begin
            if (hi_run != 0) begin
                check(hi_run, PULSE, "dot width");
                lo_run = 0;
            end
            lo_run++;
            hi_run = 0;
        end
    end

    task automatic fill(input int limit, input int exp_count);
        int got;
        int idle;
        got = 0;
        idle = 0;
        @(posedge clk);
        host.valid <= 1'b1;
        host.data <= 8'h41;
        while (idle < 5 && got < limit) begin
            @(negedge clk);
            idle = (host_ready === 1'b1) ? 0 : idle + 1;
            @(posedge clk);
            if (idle == 0) begin
                got++;
                host.data <= 8'h41 + 8'(got % 20);
            end
        end
        host.valid <= 1'b0;
        @(negedge clk);
        check(got, exp_count, "characters accepted");
        check(mech_out.main_motor, 1'b1, "motor on after store");
    endtask

    task automatic pulse_scan();
        @(posedge clk);
        scan <= 1'b1;
        repeat (20) @(posedge clk);
        scan <= 1'b0;
        @(negedge clk);
    endtask

    task automatic t_early_edge();
        fill(10, 10);
        pulse_scan();
        check(n_pulses, 0, "dots before full line");
        check(mech_out.main_motor, 1'b0, "motor stop on empty start");
        // 30 close the line, one more lands in the slot already handed off
        fill(100, 31);
    endtask

    task automatic t_print_line();
        int n;
        @(posedge clk);
        scan <= 1'b1;
        @(negedge clk);
        while (mech_in.carriage_ready !== 1'b1) @(negedge clk);
        n = 0;
        while (mech_out.hammer === 7'h00 && n < 50) begin
            @(negedge clk);
            n++;
        end
        check(n, 3, "first dot latency");
        while (mech_out.feed_motor !== 1'b1 && n < 8000) begin
            @(negedge clk);
            n++;
        end
        check(n_pulses, 200, "dots in a line");
        feed_on = 0;
        n = 0;
        while (mech_out.feed_motor === 1'b1 && n < 500) begin
            @(negedge clk);
            n++;
        end
        check(feed_on >= FEED - 2 && feed_on <= FEED + 5, 1'b1, "feed length");
        repeat (10) @(negedge clk);
        check(host_ready, 1'b1, "room after line");
        @(posedge clk);
        scan <= 1'b0;
        repeat (3) @(posedge clk);
        // drain sits on the phantom slot: the new edge must find nothing
        pulse_scan();
        check(n_pulses, 200, "no dots from phantom slot");
        check(mech_out.main_motor, 1'b0, "rearmed edge seen");
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        fails++;
        tally_and_finish();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check(mech_out, 9'h000, "reset outputs");
        check(host_ready, 1'b1, "ready after reset");
        t_early_edge();
        t_print_line();
        tally_and_finish();
    end
endmodule
`default_nettype wire
